// ==== pkg/stop_recovery_params.svh ====
// Timing and width constants for the stop-mode recovery sequencer.
// Assumes inclusion by bare name from the package and the design.
`ifndef STOP_RECOVERY_PARAMS_SVH
`define STOP_RECOVERY_PARAMS_SVH
`define RECOVERY_CNT_WIDTH 12
`define RECOVERY_LONG_CYCLES 4096
`define RECOVERY_SHORT_CYCLES 32
`endif

// ==== pkg/stop_recovery_pkg.sv ====
// Types shared by the stop-mode recovery sequencer.
// Assumes stop_recovery_params.svh is on the include path.
`include "stop_recovery_params.svh"
package stop_recovery_pkg;
  typedef enum logic [1:0] {
    RUN_ST,
    STOP_ST,
    RECOVER_ST
  } stop_state_type;
  typedef logic [`RECOVERY_CNT_WIDTH-1:0] recovery_count_type;
endpackage : stop_recovery_pkg

// ==== core/stop_mode_recovery_control.sv ====
// Stop-mode entry and recovery sequencer of the system integration unit.
// Assumes core_clk_in is the crystal reference; all inputs are same-domain.
//
// Overview of operation
// - In stop, recovery counter held at zero and CPU and peripheral clocks gated off
// - Stop entry without oscillator keep bit also disables both clockgen outputs
// - Clocks stay off after wake until recovery delay fully counted
// - Stop is left only on reset request or stop-active interrupt
// - Interrupt wake delays 32 cycles if short recovery set, else 4096
// - Interrupt stacking starts only once recovery delay has elapsed
// - Reset wake always uses the long 4096-cycle delay
// - Counter held reset from stop instruction until recovery, then counts
// - Twelve-bit recovery counter advancing once per crystal reference cycle
// - Stop instruction clears the processor interrupt mask
`include "stop_recovery_params.svh"
module stop_mode_recovery_control #(
  parameter int LONG_CYCLES = `RECOVERY_LONG_CYCLES,
  parameter int SHORT_CYCLES = `RECOVERY_SHORT_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Processor and wake sources
  input wire logic stop_exec_in,
  input wire logic wake_irq_in,
  input wire logic reset_req_in,
  // Configuration
  input wire logic stop_oscillator_keep_enable_in,
  input wire logic short_recovery_select_in,
  // Clock gating
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic clockgen_bus_output_en_out,
  output logic clockgen_crystal_reference_en_out,
  // Sequence status
  output logic stop_mode_out,
  output logic irq_mask_clear_out,
  output logic stack_start_out,
  output logic reset_release_out,
  output stop_recovery_pkg::recovery_count_type recovery_count_out
);
  import stop_recovery_pkg::*;

  // ****************************************
  // Terminal count
  // ****************************************
  function automatic recovery_count_type term_count(input logic long_sel);
    term_count = long_sel ? recovery_count_type'(LONG_CYCLES - 1) :
      recovery_count_type'(SHORT_CYCLES - 1);
  endfunction : term_count

  // ****************************************
  // Sequencer state
  // ****************************************
  stop_state_type st_q, st_d;
  recovery_count_type cnt_q, cnt_d;
  logic long_q, long_d;
  logic wake_rst_q, wake_rst_d;
  logic osc_off_q, osc_off_d;
  logic clk_en_q, clk_en_d;
  logic mclr_q, mclr_d;
  logic stack_q, stack_d;
  logic rrel_q, rrel_d;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    long_d = long_q;
    wake_rst_d = wake_rst_q;
    osc_off_d = osc_off_q;
    mclr_d = 1'b0;
    stack_d = 1'b0;
    rrel_d = 1'b0;
    unique case (st_q)
      RUN_ST: begin
        // Free-running outside stop, as after any reset
        cnt_d = cnt_q + 1'b1;
        if (stop_exec_in) begin
          st_d = STOP_ST;
          cnt_d = '0;
          mclr_d = 1'b1;
          osc_off_d = !stop_oscillator_keep_enable_in;
        end
      end
      STOP_ST: begin
        cnt_d = '0;
        // Reset checked first so it always forces the long delay
        if (reset_req_in) begin
          st_d = RECOVER_ST;
          long_d = 1'b1;
          wake_rst_d = 1'b1;
          osc_off_d = 1'b0;
        end else if (wake_irq_in) begin
          st_d = RECOVER_ST;
          long_d = !short_recovery_select_in;
          wake_rst_d = 1'b0;
          osc_off_d = 1'b0;
        end
      end
      RECOVER_ST: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == term_count(long_q)) begin
          st_d = RUN_ST;
          cnt_d = '0;
          stack_d = !wake_rst_q;
          rrel_d = wake_rst_q;
        end else if (reset_req_in) begin
          // Late reset upgrades a short interrupt recovery
          long_d = 1'b1;
          wake_rst_d = 1'b1;
        end
      end
    endcase
    clk_en_d = (st_d == RUN_ST);
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      st_q <= RUN_ST;
      cnt_q <= '0;
      long_q <= 1'b1;
      wake_rst_q <= 1'b0;
      osc_off_q <= 1'b0;
      clk_en_q <= 1'b1;
      mclr_q <= 1'b0;
      stack_q <= 1'b0;
      rrel_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      long_q <= long_d;
      wake_rst_q <= wake_rst_d;
      osc_off_q <= osc_off_d;
      clk_en_q <= clk_en_d;
      mclr_q <= mclr_d;
      stack_q <= stack_d;
      rrel_q <= rrel_d;
    end
  end

  assign cpu_clk_en_out = clk_en_q;
  assign periph_clk_en_out = clk_en_q;
  assign clockgen_bus_output_en_out = !osc_off_q;
  assign clockgen_crystal_reference_en_out = !osc_off_q;
  assign stop_mode_out = (st_q == STOP_ST);
  assign irq_mask_clear_out = mclr_q;
  assign stack_start_out = stack_q;
  assign reset_release_out = rrel_q;
  assign recovery_count_out = cnt_q;

  // ****************************************
  // Checks
  // ****************************************
  // Helper: length of the recovery just finished
  logic [12:0] rec_len_q, rec_len_d;
  // Helper: wake asked for short recovery and no reset joined in
  logic exp_short_q, exp_short_d;
  always_comb begin
    rec_len_d = (st_q == RECOVER_ST) ? rec_len_q + 13'h1 : 13'h0;
    exp_short_d = 1'b0;
    if (st_q == STOP_ST) begin
      exp_short_d = wake_irq_in && !reset_req_in &&
        short_recovery_select_in;
    end else if (st_q == RECOVER_ST) begin
      exp_short_d = exp_short_q && !reset_req_in;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      rec_len_q <= 13'h0;
      exp_short_q <= 1'b0;
    end else begin
      rec_len_q <= rec_len_d;
      exp_short_q <= exp_short_d;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  a_stop_clocks_off: assert property (
    stop_mode_out |-> !cpu_clk_en_out && !periph_clk_en_out)
    else $error("clocks running in stop");
  a_osc_off_entry: assert property (
    st_q == RUN_ST && stop_exec_in && !stop_oscillator_keep_enable_in
    |=> !clockgen_bus_output_en_out && !clockgen_crystal_reference_en_out)
    else $error("clockgen outputs left on in stop");
  a_recover_clocks_off: assert property (
    st_q == RECOVER_ST |-> !cpu_clk_en_out && !periph_clk_en_out)
    else $error("clocks on during recovery");
  a_stop_exit_cause: assert property (
    st_q == STOP_ST && !wake_irq_in && !reset_req_in |=> st_q == STOP_ST)
    else $error("stop left without wake cause");
  a_irq_delay_sel: assert property (
    stack_start_out |->
      rec_len_q == (long_q ? 13'(LONG_CYCLES) : 13'(SHORT_CYCLES)))
    else $error("wrong interrupt recovery length");
  a_short_timing: assert property (
    $rose(cpu_clk_en_out) && exp_short_q
    |-> rec_len_q == 13'(SHORT_CYCLES))
    else $error("short recovery has wrong length");
  a_stack_after_delay: assert property (
    stack_start_out |-> cpu_clk_en_out && $past(st_q) == RECOVER_ST)
    else $error("stacking before recovery end");
  a_reset_long: assert property (
    reset_release_out |-> rec_len_q == 13'(LONG_CYCLES))
    else $error("reset recovery not long");
  a_counter_held: assert property (
    st_q == STOP_ST |-> cnt_q == '0)
    else $error("counter not held in stop");
  a_counter_steps: assert property (
    st_q == RECOVER_ST && $past(st_q) == RECOVER_ST
    |-> cnt_q == recovery_count_type'($past(cnt_q) + 1'b1))
    else $error("counter did not advance");
  a_mask_clear: assert property (
    st_q == RUN_ST && stop_exec_in |=> irq_mask_clear_out ##1
      !irq_mask_clear_out)
    else $error("interrupt mask not cleared");
  a_release_together: assert property (
    $rose(cpu_clk_en_out) && $past(st_q) == RECOVER_ST
    |-> stack_start_out || reset_release_out)
    else $error("clock enable and release apart");

  c_irq_short: cover property (stack_start_out && !long_q);
  c_irq_long: cover property (stack_start_out && long_q);
  c_reset_wake: cover property (reset_release_out);
  c_osc_kept: cover property (stop_mode_out && clockgen_bus_output_en_out);
  c_late_reset: cover property (st_q == RECOVER_ST && reset_req_in && !long_q);
endmodule : stop_mode_recovery_control

// ==== tb/wake_source_model.sv ====
// Stop-active wake sources seen by the recovery sequencer.
// Assumes the bench arms it and the design reports stop via stop_mode.
module wake_source_model (
  // Clock
  input wire logic core_clk_in,
  // Bench arming
  input wire logic arm_irq_in,
  input wire logic arm_rst_in,
  // Design status
  input wire logic stop_mode_in,
  input wire logic clk_run_in,
  // Wake requests
  output logic wake_irq_out,
  output logic reset_req_out
);
  // ************************************************
  // Interrupt only in stop, reset until clocks run; falling edge
  // ************************************************
  initial begin
    wake_irq_out = 1'b0;
    reset_req_out = 1'b0;
  end
  always_ff @(negedge core_clk_in) begin
    wake_irq_out <= arm_irq_in & stop_mode_in;
    reset_req_out <= arm_rst_in & !clk_run_in;
  end
endmodule : wake_source_model

// ==== tb/stop_mode_recovery_control_bench.sv ====
// Self-checking bench for the stop-mode recovery sequencer.
// Assumes short recovery counts to shrink the run.
module stop_mode_recovery_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import stop_recovery_pkg::*;
  localparam int LONG_N = 64;
  localparam int SHORT_N = 8;
  logic core_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic stop_exec_in = 1'b0;
  logic keep_en = 1'b0;
  logic short_sel = 1'b0;
  logic arm_irq = 1'b0;
  logic arm_rst = 1'b0;
  logic wake_irq, reset_req, cpu_en, per_en, bus_en, xtal_en;
  logic stop_mode, mask_clr, stack_go, rst_done;
  recovery_count_type count;
  int bad_count = 0;
  int check_count = 0;
  always #25 core_clk_in = ~core_clk_in;
  wake_source_model u_wake_source_model (.core_clk_in(core_clk_in),
    .arm_irq_in(arm_irq), .arm_rst_in(arm_rst), .stop_mode_in(stop_mode),
    .clk_run_in(cpu_en),
    .wake_irq_out(wake_irq), .reset_req_out(reset_req));
  stop_mode_recovery_control #(.LONG_CYCLES(LONG_N),
    .SHORT_CYCLES(SHORT_N)) u_stop_mode_recovery_control (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .stop_exec_in(stop_exec_in), .wake_irq_in(wake_irq),
    .reset_req_in(reset_req), .stop_oscillator_keep_enable_in(keep_en),
    .short_recovery_select_in(short_sel), .cpu_clk_en_out(cpu_en),
    .periph_clk_en_out(per_en), .clockgen_bus_output_en_out(bus_en),
    .clockgen_crystal_reference_en_out(xtal_en), .stop_mode_out(stop_mode),
    .irq_mask_clear_out(mask_clr), .stack_start_out(stack_go),
    .reset_release_out(rst_done), .recovery_count_out(count));
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask : check
  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  // ************************************************
  // Stop entry, stray requests ignored while stopped
  // ************************************************
  task automatic enter_stop(input logic keep);
    recovery_count_type c;
    @(negedge core_clk_in);
    c = count;
    @(negedge core_clk_in);
    check(count === c + 12'h001, "free run count");
    keep_en = keep;
    stop_exec_in = 1'b1;
    @(negedge core_clk_in);
    stop_exec_in = 1'b0;
    check(count === 12'h000, "count cleared");
    check(stop_mode === 1'b1 && mask_clr === 1'b1, "stop entry");
    check(cpu_en === 1'b0 && per_en === 1'b0, "clocks off");
    check(bus_en === keep && xtal_en === keep, "clockgen gating");
    @(negedge core_clk_in);
    stop_exec_in = 1'b1;
    check(mask_clr === 1'b0, "mask pulse width");
    repeat (3) @(negedge core_clk_in);
    stop_exec_in = 1'b0;
    check(stop_mode === 1'b1 && count === 12'h000, "held stopped");
    check(cpu_en === 1'b0 && per_en === 1'b0, "clocks stay off");
  endtask : enter_stop
  // ************************************************
  // Wake and time the recovery delay
  // ************************************************
  task automatic wake(input logic by_rst, input logic shrt, input int late,
    input int n);
    int k;
    logic rr;
    rr = by_rst | (late > 0);
    short_sel = shrt;
    arm_rst = by_rst;
    arm_irq = ~by_rst;
    k = 0;
    while (stop_mode !== 1'b0) begin
      @(negedge core_clk_in);
      k++;
      if (k > 20) begin
        check(1'b0, "no wake");
        wrap_up();
      end
    end
    arm_irq = 1'b0;
    check(bus_en === 1'b1 && xtal_en === 1'b1, "osc back");
    k = 0;
    while (cpu_en !== 1'b1) begin
      check(per_en === 1'b0 && stack_go === 1'b0, "early run");
      // Late reset pulse only when asked, else keeps the request low
      arm_rst = (late > 0 && k == late);
      @(negedge core_clk_in);
      k++;
      if (k > 5000) begin
        check(1'b0, "no recovery");
        wrap_up();
      end
    end
    check(k == n, "recovery length");
    check(per_en === 1'b1, "periph with cpu");
    check(stack_go === ~rr && rst_done === rr, "release");
  endtask : wake
  // ************************************************
  // Reset arriving during a short interrupt recovery
  // ************************************************
  task automatic late_reset();
    enter_stop(1'b0);
    wake(1'b0, 1'b1, 3, LONG_N);
  endtask : late_reset
  // ************************************************
  // System reset taken while stopped
  // ************************************************
  task automatic reset_in_stop();
    enter_stop(1'b0);
    nrst_in = 1'b0;
    repeat (2) @(negedge core_clk_in);
    nrst_in = 1'b1;
    check(stop_mode === 1'b0 && count === 12'h000, "reset exit");
    check(cpu_en === 1'b1 && per_en === 1'b1, "clocks after reset");
    check(bus_en === 1'b1 && xtal_en === 1'b1, "clockgen after rst");
    @(negedge core_clk_in);
    check(count === 12'h001, "count after reset");
  endtask : reset_in_stop
  initial begin
    repeat (10) @(negedge core_clk_in);
    nrst_in = 1'b1;
    enter_stop(1'b0);
    wake(1'b0, 1'b1, 0, SHORT_N);
    enter_stop(1'b1);
    wake(1'b1, 1'b1, 0, LONG_N);
    enter_stop(1'b0);
    wake(1'b0, 1'b0, 0, LONG_N);
    late_reset();
    reset_in_stop();
    wrap_up();
  end
endmodule : stop_mode_recovery_control_bench
